// ===== common/ubsm_pkg.sv
// constants and register map for the bus-collision / smart-card serial channel
// assumes an apb slave with 32-bit data, one aligned word per register
//
// Summary of operation
// [R1] collision bus mode sends each bus bit as one full character frame
// [R2] collision mode flags collision when driven tx level differs from sampled rx
// [R3] software selects mode 110b, no parity, one stop bit for collision mode
// [R4] software picks collision sample instant and transmit start condition
// [R5] with auto-clear set, a collision clears the transmit enable
// [R6] channels 0 and 1 need two enable bits set before collision works
// [R7] collision mode allows line polarity inversion and internal or external clock
// [R8] smart-card bit clock is source divided by 16*(n+1), n 00h..FFh
// [R9] transmit starts only with tx enable set and buffer-empty flag clear
// [R10] receive starts only with rx enable set and a start bit seen
// [R11] tx interrupt at shift-out done with tx_int_source_select set, else at buffer load; rx interrupt when buffer loaded
// [R12] overrun when next character nears last stop with buffer unread
// [R13] framing error on missing stop; flags update on buffer load
// [R14] error sum flag set when any overrun, framing or parity error occurs
// [R15] with error output enabled, parity error on receive drives tx low
// [R16] reading rx buffer during error signal clears parity flag, releases tx
// [R17] transmission complete request follows stop bit at transfer clock edge
// [R18] software samples rx line in tx-complete handler to see card error
// [R19] direct format: lsb first, no inversion, even parity
// [R20] inverse format: inverted, msb first, odd parity both ways
// [R21] software selects 101b, parity, tx-complete source, error output enable
// [R22] software clears spurious tx request after configuring smart-card mode
// [R23] frame is start, eight data, parity, stop, sampled at bit middle
package ubsm_pkg;
  // register byte offsets
  localparam logic [7:0] UBSM_OFS_TXBUF  = 8'h00;
  localparam logic [7:0] UBSM_OFS_RXBUF  = 8'h04;
  localparam logic [7:0] UBSM_OFS_BAUD   = 8'h08;
  localparam logic [7:0] UBSM_OFS_MODE   = 8'h0C;
  localparam logic [7:0] UBSM_OFS_CTRL   = 8'h10;
  localparam logic [7:0] UBSM_OFS_STAT   = 8'h14;
  localparam logic [7:0] UBSM_OFS_INTSEL = 8'h18;
  // mode register fields
  localparam int UBSM_MD_SEL_LO   = 0;  // serial_mode_select [2:0]
  localparam int UBSM_MD_CLKSRC   = 3;  // clock_source_select
  localparam int UBSM_MD_STOP2    = 4;  // stop_bit_count
  localparam int UBSM_MD_PODD     = 5;  // parity_odd_even_select (1 even)
  localparam int UBSM_MD_PEN      = 6;  // parity_enable
  localparam int UBSM_MD_POL      = 7;  // line_polarity_invert
  localparam int UBSM_MD_MSBF     = 8;  // bit_order_select
  localparam int UBSM_MD_INV      = 9;  // data_logic_invert
  localparam int UBSM_MD_ERE      = 10; // error_signal_output_enable
  localparam int UBSM_MD_TXIRS    = 11; // tx_int_source_select
  localparam int UBSM_MD_SAMP     = 12; // collision_sample_timing
  localparam int UBSM_MD_TX_ENABLE_AUTO_CLEAR     = 13; // tx_enable_auto_clear
  localparam int UBSM_MD_SSS      = 14; // tx_start_condition_select
  localparam int UBSM_MD_PRESC_LO = 16; // internal prescale select [17:16]
  localparam int UBSM_MD_W        = 18;
  // control register fields
  localparam int UBSM_CT_TE       = 0;
  localparam int UBSM_CT_RE       = 1;
  // status fields (read)
  localparam int UBSM_ST_TI   = 0;  // tx_buffer_empty_flag
  localparam int UBSM_ST_TXE  = 1;  // shift register empty
  localparam int UBSM_ST_RI   = 2;  // rx_complete_flag
  localparam int UBSM_ST_OER  = 3;
  localparam int UBSM_ST_FER  = 4;
  localparam int UBSM_ST_PER  = 5;
  localparam int UBSM_ST_SUM  = 6;
  localparam int UBSM_ST_BCOL = 7;  // sticky collision seen
  localparam int UBSM_ST_TXIR = 8;  // tx int_request_flag
  localparam int UBSM_ST_RXIR = 9;  // rx int_request_flag
  // int_source_select_reg fields
  localparam int UBSM_IS_CH0 = 6;   // collision_enable_ch0
  localparam int UBSM_IS_CH1 = 7;   // collision_enable_ch1
  // mode codes
  localparam logic [2:0] UBSM_MODE_BUS = 3'b110;
  localparam logic [2:0] UBSM_MODE_SIM = 3'b101;
  // frame timing in 16x ticks
  localparam logic [3:0] UBSM_OVS_LAST = 4'hF;
  localparam logic [3:0] UBSM_OVS_MID  = 4'h7;
  localparam logic [3:0] UBSM_DATA_N   = 4'h8;
  typedef enum logic [2:0] {
    UBSM_IDLE   = 3'b000,
    UBSM_START  = 3'b001,
    UBSM_DATA   = 3'b010,
    UBSM_PARITY = 3'b011,
    UBSM_STOP   = 3'b100
  } ubsm_state_t;
endpackage : ubsm_pkg

// ===== core/ubsm_baud.sv
// 16x baud tick generator: selected source divided by n+1
// assumes ext pin already synchronised by the caller
`timescale 1ns/1ps
module ubsm_baud
  import ubsm_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       ce,
  input  wire logic [1:0] prescSel,
  input  wire logic       extSel,
  input  wire logic       extLevel,
  input  wire logic [7:0] divN,
  output logic            tick16
);
  logic [4:0] preCnt_q;
  logic       extPrev_q;
  logic       srcEn;
  logic [7:0] divCnt_q;

  // free prescaler for internal sources /1 /2 /8 /32
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) preCnt_q <= 5'h00;
    else if (ce) preCnt_q <= preCnt_q + 5'h01;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) extPrev_q <= 1'b0;
    else if (ce) extPrev_q <= extLevel;
  end

  // external source counts rising edges of the clock pin
  always_comb begin
    if (extSel) srcEn = extLevel & ~extPrev_q;
    else begin
      case (prescSel)
        2'h0:    srcEn = 1'b1;
        2'h1:    srcEn = preCnt_q[0];
        2'h2:    srcEn = &preCnt_q[2:0];
        default: srcEn = &preCnt_q;
      endcase
    end
  end

  // reload divider giving n+1 source events per 16x tick
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      divCnt_q <= 8'h00;
      tick16   <= 1'b0;
    end else if (ce) begin
      tick16 <= 1'b0;
      if (srcEn) begin
        if (divCnt_q == 8'h00) begin
          divCnt_q <= divN;
          tick16   <= 1'b1; // [R8]
        end else divCnt_q <= divCnt_q - 8'h01;
      end
    end
  end
endmodule : ubsm_baud

// ===== core/ubsm_rx.sv
// receive shifter: start, 8 data, optional parity, 1 or 2 stops
// assumes rxLine is synchronised and already polarity-corrected
`timescale 1ns/1ps
module ubsm_rx
  import ubsm_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       ce,
  input  wire logic       tick16,
  input  wire logic       rxEn,
  input  wire logic       rxLine,
  input  wire logic       parEn,
  input  wire logic       stop2,
  output logic [7:0]      shiftData,
  output logic            parOk,
  output logic            stopOk,
  output logic            nearEnd,
  output logic            done
);
  ubsm_state_t st_q;
  logic [3:0]  ovs_q;
  logic [3:0]  bitCnt_q;
  logic        par_q;
  logic        mid;
  assign mid = tick16 && (ovs_q == UBSM_OVS_MID);

  // mid-bit sampling state machine
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= UBSM_IDLE; ovs_q <= 4'h0; bitCnt_q <= 4'h0; par_q <= 1'b0;
      shiftData <= 8'h00; parOk <= 1'b0; stopOk <= 1'b0; done <= 1'b0; nearEnd <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      nearEnd <= 1'b0;
      if (tick16) ovs_q <= ovs_q + 4'h1;
      case (st_q)
        UBSM_IDLE: if (rxEn && !rxLine) begin // [R10]
          st_q <= UBSM_START; ovs_q <= 4'h0;
        end
        UBSM_START: if (mid) begin
          if (rxLine) st_q <= UBSM_IDLE; // glitch, not a start
          else begin st_q <= UBSM_DATA; bitCnt_q <= 4'h0; par_q <= 1'b0; end
        end
        UBSM_DATA: if (mid) begin // [R23]
          shiftData <= {rxLine, shiftData[7:1]};
          par_q     <= par_q ^ rxLine;
          bitCnt_q  <= bitCnt_q + 4'h1;
          if (bitCnt_q == UBSM_DATA_N - 4'h1) begin
            st_q <= parEn ? UBSM_PARITY : UBSM_STOP;
            bitCnt_q <= 4'h0;
            if (!parEn && !stop2) nearEnd <= 1'b1; // bit before last stop
          end
        end
        UBSM_PARITY: if (mid) begin
          par_q <= par_q ^ rxLine;
          st_q  <= UBSM_STOP;
          if (!stop2) nearEnd <= 1'b1; // [R12]
        end
        UBSM_STOP: if (mid) begin
          stopOk   <= (bitCnt_q == 4'h0) ? rxLine : (stopOk & rxLine); // [R13]
          bitCnt_q <= bitCnt_q + 4'h1;
          if (stop2 && bitCnt_q == 4'h0) nearEnd <= 1'b1;
          if (!stop2 || bitCnt_q != 4'h0) begin
            parOk <= ~par_q;  // even over data+parity
            st_q  <= UBSM_IDLE;
            done  <= 1'b1;
          end
        end
        default: st_q <= UBSM_IDLE;
      endcase
    end
  end
endmodule : ubsm_rx

// ===== core/ubsm_top.sv
// serial channel with collision-detect bus mode and smart-card mode
// assumes apb master on clk; line pins asynchronous, synchronised here
//
// Chosen here: the address map and register access over APB.
`timescale 1ns/1ps
module ubsm_top
  import ubsm_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        serialInPin,
  input  wire logic        externalClockPin,
  output logic             serialOutPin,
  output logic             serialOutOe_b,
  output logic             txIntReq,
  output logic             rxIntReq,
  output logic             collisionIntReq
);
  logic [UBSM_MD_W-1:0] mode_q;
  logic [7:0]  baud_q;
  logic        txEn_q, rxEn_q;
  logic [7:0]  intSel_q;
  logic [8:0]  txBuf_q;
  logic        txEmpty_q;
  logic [7:0]  rxBuf_q;
  logic        ri_q, oer_q, fer_q, per_q, bcol_q;
  logic        perSig_q;
  logic        rxS1_q, rxS2_q, ckS1_q, ckS2_q;
  logic        apbWr, apbRd, rxRead;
  logic        sim, busMode, collArmed;
  logic        tick16;
  logic        rxLine;
  logic [7:0]  rxShift;
  logic        rxParOk, rxStopOk, rxNear, rxDone;
  ubsm_state_t txSt_q;
  logic [3:0]  txOvs_q, txBit_q;
  logic [7:0]  txSh_q;
  logic        txPar_q, txLvl_q, txDone, txLoad;
  logic        collide;

  assign sim       = mode_q[UBSM_MD_SEL_LO +: 3] == UBSM_MODE_SIM;
  assign busMode   = mode_q[UBSM_MD_SEL_LO +: 3] == UBSM_MODE_BUS;
  // channels 0 and 1 gate detection on the select bits
  assign collArmed = busMode && intSel_q[UBSM_IS_CH0] && intSel_q[UBSM_IS_CH1]; // [R6]
  assign apbWr     = psel && penable && pwrite;
  assign apbRd     = psel && penable && !pwrite;
  assign rxRead    = apbRd && paddr == UBSM_OFS_RXBUF;

  // two-flop synchronisers on both pins
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rxS1_q <= 1'b1; rxS2_q <= 1'b1; ckS1_q <= 1'b0; ckS2_q <= 1'b0;
    end else if (ce) begin
      rxS1_q <= serialInPin; rxS2_q <= rxS1_q;
      ckS1_q <= externalClockPin; ckS2_q <= ckS1_q;
    end
  end
  assign rxLine = rxS2_q ^ mode_q[UBSM_MD_POL]; // [R7]

  ubsm_baud u_baud (
    .clk      (clk),
    .rst_b    (rst_b),
    .ce       (ce),
    .prescSel (mode_q[UBSM_MD_PRESC_LO +: 2]),
    .extSel   (mode_q[UBSM_MD_CLKSRC]), // [R7]
    .extLevel (ckS2_q),
    .divN     (baud_q),
    .tick16   (tick16)
  );

  ubsm_rx u_rx (
    .clk       (clk),
    .rst_b     (rst_b),
    .ce        (ce),
    .tick16    (tick16),
    .rxEn      (rxEn_q),
    .rxLine    (rxLine),
    .parEn     (mode_q[UBSM_MD_PEN]),
    .stop2     (mode_q[UBSM_MD_STOP2]),
    .shiftData (rxShift),
    .parOk     (rxParOk),
    .stopOk    (rxStopOk),
    .nearEnd   (rxNear),
    .done      (rxDone)
  );

  // configuration registers; collision may auto-clear tx enable
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_q <= '0; baud_q <= 8'h00; txEn_q <= 1'b0; rxEn_q <= 1'b0; intSel_q <= 8'h00;
    end else if (ce) begin
      if (apbWr && paddr == UBSM_OFS_MODE)   mode_q   <= pwdata[UBSM_MD_W-1:0];
      if (apbWr && paddr == UBSM_OFS_BAUD)   baud_q   <= pwdata[7:0];
      if (apbWr && paddr == UBSM_OFS_INTSEL) intSel_q <= pwdata[7:0];
      if (apbWr && paddr == UBSM_OFS_CTRL) begin
        txEn_q <= pwdata[UBSM_CT_TE];
        rxEn_q <= pwdata[UBSM_CT_RE];
      end
      if (collide && mode_q[UBSM_MD_TX_ENABLE_AUTO_CLEAR]) txEn_q <= 1'b0; // [R5]
    end
  end

  // tx buffer: write clears empty flag, shifter load sets it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      txBuf_q <= 9'h000; txEmpty_q <= 1'b1;
    end else if (ce) begin
      if (txLoad) txEmpty_q <= 1'b1;
      if (apbWr && paddr == UBSM_OFS_TXBUF) begin
        txBuf_q <= pwdata[8:0]; txEmpty_q <= 1'b0;
      end
    end
  end

  // start needs enable and data; in bus mode sss adds wait for idle high rx line
  assign txLoad = txSt_q == UBSM_IDLE && txEn_q && !txEmpty_q && tick16 &&
                  (!(busMode && mode_q[UBSM_MD_SSS]) || rxLine); // [R9] [R4]

  // transmit frame, one full character per bus bit in collision mode
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      txSt_q <= UBSM_IDLE; txOvs_q <= 4'h0; txBit_q <= 4'h0; txSh_q <= 8'h00;
      txPar_q <= 1'b0; txLvl_q <= 1'b1; txDone <= 1'b0;
    end else if (ce) begin
      txDone <= 1'b0;
      if (tick16 && txSt_q != UBSM_IDLE) txOvs_q <= txOvs_q + 4'h1;
      if (txLoad) begin // [R1]
        txSt_q  <= UBSM_START; txOvs_q <= 4'h0; txLvl_q <= 1'b0; txBit_q <= 4'h0;
        txSh_q  <= mode_q[UBSM_MD_INV] ? ~txBuf_q[7:0] : txBuf_q[7:0]; // [R20]
        txPar_q <= ~mode_q[UBSM_MD_PODD]; // odd seeds 1, even seeds 0 [R19]
      end else if (tick16 && txOvs_q == UBSM_OVS_LAST) begin
        case (txSt_q)
          UBSM_START, UBSM_DATA: begin
            if (txSt_q == UBSM_DATA && txBit_q == UBSM_DATA_N) begin
              txSt_q  <= mode_q[UBSM_MD_PEN] ? UBSM_PARITY : UBSM_STOP;
              txLvl_q <= mode_q[UBSM_MD_PEN] ? txPar_q : 1'b1;
              txBit_q <= 4'h0;
            end else begin
              txSt_q  <= UBSM_DATA;
              // msb-first shifts from bit 7, lsb-first from bit 0
              txLvl_q <= mode_q[UBSM_MD_MSBF] ? txSh_q[7] : txSh_q[0]; // [R19] [R20]
              txPar_q <= txPar_q ^ (mode_q[UBSM_MD_MSBF] ? txSh_q[7] : txSh_q[0]);
              txSh_q  <= mode_q[UBSM_MD_MSBF] ? {txSh_q[6:0], 1'b0} : {1'b0, txSh_q[7:1]};
              txBit_q <= txBit_q + 4'h1;
            end
          end
          UBSM_PARITY: begin
            txSt_q <= UBSM_STOP; txLvl_q <= 1'b1;
          end
          UBSM_STOP: begin
            txBit_q <= txBit_q + 4'h1;
            if (!mode_q[UBSM_MD_STOP2] || txBit_q != 4'h0) begin
              txSt_q <= UBSM_IDLE;
              txDone <= 1'b1; // first edge after stop [R17]
            end
          end
          default: txSt_q <= UBSM_IDLE;
        endcase
      end
    end
  end

  // compare driven and sampled level at chosen instant
  assign collide = collArmed && txSt_q != UBSM_IDLE && tick16 &&
                   txOvs_q == (mode_q[UBSM_MD_SAMP] ? UBSM_OVS_LAST : UBSM_OVS_MID) &&
                   txLvl_q != rxLine; // [R2] [R4]

  // receive buffer and error flags; set wins over the read clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rxBuf_q <= 8'h00; ri_q <= 1'b0; oer_q <= 1'b0; fer_q <= 1'b0; per_q <= 1'b0;
      perSig_q <= 1'b0; bcol_q <= 1'b0;
    end else if (ce) begin
      if (rxRead) begin
        ri_q <= 1'b0; oer_q <= 1'b0; fer_q <= 1'b0; per_q <= 1'b0;
        perSig_q <= 1'b0; // release tx line [R16]
      end
      if (rxNear && ri_q && !rxRead) oer_q <= 1'b1; // [R12]
      if (rxDone) begin // [R11]
        if (!(ri_q && !rxRead)) rxBuf_q <= mode_q[UBSM_MD_INV] ?
            ~{rxShift[0], rxShift[1], rxShift[2], rxShift[3],
              rxShift[4], rxShift[5], rxShift[6], rxShift[7]} : rxShift; // [R20]
        ri_q  <= 1'b1;
        fer_q <= !rxStopOk; // [R13]
        per_q <= mode_q[UBSM_MD_PEN] &&
                 (rxParOk != mode_q[UBSM_MD_PODD]); // [R19] [R20]
        if (sim && mode_q[UBSM_MD_ERE] && mode_q[UBSM_MD_PEN] &&
            rxParOk != mode_q[UBSM_MD_PODD]) perSig_q <= 1'b1; // [R15]
      end
      if (collide) bcol_q <= 1'b1;
      if (apbWr && paddr == UBSM_OFS_STAT && pwdata[UBSM_ST_BCOL] && !collide) bcol_q <= 1'b0;
    end
  end

  // interrupt request pulses and pin drive, all registered
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      txIntReq <= 1'b0; rxIntReq <= 1'b0; collisionIntReq <= 1'b0;
      serialOutPin <= 1'b1; serialOutOe_b <= 1'b1;
    end else if (ce) begin
      txIntReq <= mode_q[UBSM_MD_TXIRS] ? txDone : txLoad; // [R11] [R17]
      rxIntReq <= rxDone && !(ri_q && !rxRead); // overrun leaves request alone [R12]
      collisionIntReq <= collide; // [R2]
      serialOutPin  <= (txLvl_q & ~perSig_q) ^ mode_q[UBSM_MD_POL]; // [R15] [R7]
      serialOutOe_b <= 1'b0;
    end
  end

  // apb slave, zero wait states, error on unmapped offsets
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000; pready <= 1'b0; pslverr <= 1'b0;
    end else if (ce) begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        prdata <= 32'h0000_0000;
        case (paddr)
          UBSM_OFS_TXBUF:  prdata[8:0] <= txBuf_q;
          UBSM_OFS_RXBUF:  prdata[7:0] <= rxBuf_q;
          UBSM_OFS_BAUD:   prdata[7:0] <= baud_q;
          UBSM_OFS_MODE:   prdata[UBSM_MD_W-1:0] <= mode_q;
          UBSM_OFS_CTRL:   prdata[1:0] <= {rxEn_q, txEn_q};
          UBSM_OFS_STAT:   prdata[9:0] <= {rxIntReq, txIntReq, bcol_q,
                             oer_q | fer_q | per_q, per_q, fer_q, oer_q, ri_q,
                             txSt_q == UBSM_IDLE, txEmpty_q}; // [R14]
          UBSM_OFS_INTSEL: prdata[7:0] <= intSel_q;
          default:         pslverr <= 1'b1;
        endcase
      end
    end
  end
endmodule : ubsm_top

// ===== testbench/ubsm_top_checker.sv
// checks on the top ports: bus handshake, event pulses, line release
// assumes it is bound to ubsm_top and sees only its ports
`timescale 1ns/1ps
module ubsm_top_checker
  import ubsm_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        serialOutPin,
  input wire logic        serialOutOe_b,
  input wire logic        txIntReq,
  input wire logic        rxIntReq,
  input wire logic        collisionIntReq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  pready_access_a: assert property (psel && penable |-> pready)
    else $error("no ready in access phase");
  pready_cause_a: assert property (pready |-> psel && penable && $past(psel) && !$past(penable))
    else $error("ready out of place");
  slverr_map_a: assert property (pready |->
    pslverr == (paddr > UBSM_OFS_INTSEL || paddr[1:0] != 2'b00))
    else $error("error response off map");
  err_data_a: assert property (pslverr && !pwrite |-> prdata == 32'h0 ##1 !pslverr)
    else $error("refused read gave data");
  oe_drive_a: assert property ($past(rst_b) |-> !serialOutOe_b)
    else $error("line not driven");
  tx_pulse_a: assert property (txIntReq |=> !txIntReq)
    else $error("long tx request");
  rx_pulse_a: assert property (rxIntReq |=> !rxIntReq)
    else $error("long rx request");
  col_pulse_a: assert property (collisionIntReq |=> !collisionIntReq)
    else $error("long collision request");
  rd_release_a: assert property (pready && !pwrite && paddr == UBSM_OFS_RXBUF |->
    ##[1:3] serialOutPin)
    else $error("line not released after read");
endmodule : ubsm_top_checker

bind ubsm_top ubsm_top_checker i_ubsm_top_checker (.clk, .rst_b, .psel, .penable, .pwrite,
  .paddr, .prdata, .pready, .pslverr, .serialOutPin, .serialOutOe_b, .txIntReq, .rxIntReq,
  .collisionIntReq);

// ===== testbench/ubsm_card_model.sv
// card or bus node on the far side of the serial line
// assumes a wired-and line with pull-up; bench sets bitLen in clk cycles
`timescale 1ns/1ps
module ubsm_card_model (
  input  wire logic clk,
  input  wire logic devLine,
  output logic      cardOut
);
  int          bitLen   = 16;
  int          gotCnt   = 0;
  int          startLen = 0;
  logic        holdLow  = 1'b0;
  logic        drv      = 1'b1;
  logic [10:0] got      = 11'h000;
  logic        line;
  // released output floats to the pull-up level; holdLow forces a clash
  assign cardOut = drv & ~holdLow;
  assign line    = devLine & cardOut;
  // one frame, start bit first, each bit held bitLen cycles
  task automatic send(input logic [10:0] f);
    for (int k = 0; k < 11; k++) begin
      @(posedge clk);
      drv <= f[k];
      repeat (bitLen - 1) @(posedge clk);
    end
    @(posedge clk);
    drv <= 1'b1;
  endtask : send
  // capture: sample mid bit, measure the start bit length
  initial begin
    forever begin
      @(negedge line);
      startLen = 0;
      for (int c = 0; c < 11 * bitLen; c++) begin
        @(posedge clk);
        if (c == startLen && line == 1'b0) startLen++;
        if (c % bitLen == bitLen / 2) got[c / bitLen] = line;
      end
      gotCnt++;
    end
  end
endmodule : ubsm_card_model

// ===== testbench/uart_bus_collision_and_sim_modes_tb.sv
// self-checking bench for the serial channel top
// assumes the card model shares a wired-and line with pull-up
`timescale 1ns/1ps
module uart_bus_collision_and_sim_modes_tb;
  import ubsm_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr  = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, er, serialOutPin, serialOutOe_b, devLine, cardOut;
  logic        serialInPin, txIntReq, rxIntReq, collisionIntReq;
  int          err_total = 0, cmp_count = 0, cyc = 0, txCnt = 0, rxCnt = 0, colCnt = 0;
  assign devLine     = serialOutOe_b ? 1'b1 : serialOutPin;
  assign serialInPin = devLine & cardOut;
  always #20 clk = ~clk;
  // event counters and hang guard
  always @(posedge clk) begin
    cyc++;
    if (txIntReq === 1'b1) txCnt++;
    if (rxIntReq === 1'b1) rxCnt++;
    if (collisionIntReq === 1'b1) colCnt++;
    if (cyc == 20000) begin
      err_total++;
      close_out();
    end
  end
  ubsm_top i_ubsm_top (.clk, .rst_b, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .serialInPin, .externalClockPin(1'b0), .serialOutPin, .serialOutOe_b,
    .txIntReq, .rxIntReq, .collisionIntReq);
  ubsm_card_model i_ubsm_card_model (.clk, .devLine, .cardOut);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // line frame; inverse is inverted msb first
  function automatic logic [10:0] mk(input logic [7:0] d, input logic inv, input logic bad,
                                     input logic stp);
    logic [7:0] l;
    for (int k = 0; k < 8; k++) l[k] = inv ? ~d[7 - k] : d[k];
    return {stp, ^l ^ inv ^ bad, l, 1'b0};
  endfunction : mk
  function automatic logic [31:0] mode(input logic inv);
    return 32'(UBSM_MODE_SIM) | (32'h1 << UBSM_MD_PEN) | (32'h1 << UBSM_MD_ERE)
         | (32'h1 << UBSM_MD_TXIRS) | (inv ? (32'h3 << UBSM_MD_MSBF) : (32'h1 << UBSM_MD_PODD));
  endfunction : mode
  task automatic t_regs();
    apb(1'b0, UBSM_OFS_STAT, 32'h0);
    chk(rd & 32'h3FC, 32'h0);
    apb(1'b0, 8'h1C, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, UBSM_OFS_BAUD, 32'hFF);
    apb(1'b0, UBSM_OFS_BAUD, 32'h0);
    chk(rd, 32'hFF);
    $display("regs test ended");
  endtask : t_regs
  // one card character, held back until tx enable is set
  task automatic t_tx(input logic inv, input logic [7:0] d, input logic [7:0] n);
    int g, t0, bl;
    bl = 16 * (n + 1);
    i_ubsm_card_model.bitLen = bl;
    apb(1'b1, UBSM_OFS_BAUD, 32'(n));
    apb(1'b1, UBSM_OFS_MODE, mode(inv));
    apb(1'b1, UBSM_OFS_CTRL, 32'h0);
    g = i_ubsm_card_model.gotCnt;
    t0 = txCnt;
    apb(1'b1, UBSM_OFS_TXBUF, 32'(d));
    repeat (3 * bl) @(posedge clk);
    chk(32'(i_ubsm_card_model.gotCnt - g), 32'h0);
    apb(1'b1, UBSM_OFS_CTRL, 32'h1);
    while (i_ubsm_card_model.gotCnt == g) @(posedge clk);
    chk({31'h0, serialInPin}, 32'h1);
    repeat (2 * bl) @(posedge clk);
    chk(32'(i_ubsm_card_model.startLen), 32'(bl));
    chk(32'(i_ubsm_card_model.got), 32'(mk(d, inv, 1'b0, 1'b1)));
    chk(32'(txCnt - t0), 32'h1);
    $display("tx test ended");
  endtask : t_tx
  // drop reception, clear flags left by the line
  task automatic rx_clean();
    apb(1'b1, UBSM_OFS_CTRL, 32'h0);
    repeat (200) @(posedge clk);
    apb(1'b0, UBSM_OFS_RXBUF, 32'h0);
  endtask : rx_clean
  task automatic t_rx(input logic inv, input logic [7:0] d, input logic bad, input logic stp);
    int r0;
    i_ubsm_card_model.bitLen = 16;
    apb(1'b1, UBSM_OFS_BAUD, 32'h0);
    apb(1'b1, UBSM_OFS_MODE, mode(inv));
    apb(1'b1, UBSM_OFS_CTRL, 32'h2);
    r0 = rxCnt;
    i_ubsm_card_model.send(mk(d, inv, bad, stp));
    repeat (8) @(posedge clk);
    chk(32'(rxCnt - r0), 32'h1);
    if (bad) chk({31'h0, serialOutPin}, 32'h0);
    apb(1'b0, UBSM_OFS_STAT, 32'h0);
    chk({31'h0, rd[UBSM_ST_PER]}, {31'h0, bad});
    if (!bad) chk({31'h0, rd[UBSM_ST_FER]}, {31'h0, ~stp});
    chk({31'h0, rd[UBSM_ST_SUM]}, {31'h0, bad | ~stp});
    apb(1'b0, UBSM_OFS_RXBUF, 32'h0);
    if (!bad && stp) chk(rd & 32'hFF, 32'(d));
    repeat (4) @(posedge clk);
    chk({31'h0, serialOutPin}, 32'h1);
    apb(1'b0, UBSM_OFS_STAT, 32'h0);
    chk({31'h0, rd[UBSM_ST_PER]}, 32'h0);
    rx_clean();
    $display("rx test ended");
  endtask : t_rx
  task automatic t_over();
    int r0;
    apb(1'b1, UBSM_OFS_MODE, mode(1'b0));
    apb(1'b1, UBSM_OFS_CTRL, 32'h2);
    r0 = rxCnt;
    i_ubsm_card_model.send(mk(8'h11, 1'b0, 1'b0, 1'b1));
    i_ubsm_card_model.send(mk(8'h22, 1'b0, 1'b0, 1'b1));
    repeat (8) @(posedge clk);
    chk(32'(rxCnt - r0), 32'h1);
    apb(1'b0, UBSM_OFS_STAT, 32'h0);
    chk(rd & 32'h48, 32'h48);
    apb(1'b0, UBSM_OFS_RXBUF, 32'h0);
    chk(rd & 32'hFF, 32'h11);
    rx_clean();
    $display("overrun test ended");
  endtask : t_over
  // bus mode: clean loop-back, then a node holding the line low
  task automatic t_col();
    int g, c0;
    // sample at bit end plus auto-clear: bits 12 and 13
    apb(1'b1, UBSM_OFS_MODE, 32'(UBSM_MODE_BUS) | (32'h3 << UBSM_MD_SAMP));
    apb(1'b1, UBSM_OFS_INTSEL, 32'hC0);
    apb(1'b1, UBSM_OFS_CTRL, 32'h1);
    g = i_ubsm_card_model.gotCnt;
    c0 = colCnt;
    apb(1'b1, UBSM_OFS_TXBUF, 32'h55);
    while (i_ubsm_card_model.gotCnt == g) @(posedge clk);
    chk(32'(i_ubsm_card_model.got[9:0]), 32'h2AA);
    chk(32'(colCnt - c0), 32'h0);
    i_ubsm_card_model.holdLow <= 1'b1;
    apb(1'b1, UBSM_OFS_TXBUF, 32'hFF);
    repeat (192) @(posedge clk);
    i_ubsm_card_model.holdLow <= 1'b0;
    chk({31'h0, colCnt != c0}, 32'h1);
    apb(1'b0, UBSM_OFS_CTRL, 32'h0);
    chk(rd & 32'h1, 32'h0);
    apb(1'b0, UBSM_OFS_STAT, 32'h0);
    chk(rd & 32'h80, 32'h80);
    $display("collision test ended");
  endtask : t_col
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    t_regs();
    t_tx(1'b0, 8'hA5, 8'h02);
    t_tx(1'b1, 8'h3C, 8'h00);
    t_rx(1'b0, 8'h5A, 1'b0, 1'b1);
    t_rx(1'b1, 8'hC3, 1'b0, 1'b1);
    t_rx(1'b0, 8'h96, 1'b1, 1'b1);
    t_rx(1'b0, 8'h0F, 1'b0, 1'b0);
    t_over();
    t_col();
    close_out();
  end
endmodule : uart_bus_collision_and_sim_modes_tb
